// ===== rtl/lds_cfg.svh
`ifndef LDS_CFG_SVH
`define LDS_CFG_SVH

// Register offsets
`define LDS_ADDR_DRV_MODE 7'h03
`define LDS_ADDR_DRV_CTRL1 7'h05
`define LDS_ADDR_AMP_CTRL 7'h0C
`define LDS_ADDR_DIAG_CTRL 7'h0E
`define LDS_ADDR_DIAG_RES 7'h12
`define LDS_ADDR_IRQ_STAT3 7'h15

// Reset values
`define LDS_RST_DRV_MODE 3'h1
`define LDS_RST_DRV_CTRL1 8'h1E
`define LDS_RST_AMP_CTRL 8'hA0
`define LDS_RST_DIAG_CTRL 8'h00

// Writable bit masks
`define LDS_MASK_AMP_CTRL 8'hAF
`define LDS_MASK_DIAG_CTRL 8'h7F

// Field positions
`define LDS_BIT_AMP3_EN 7
`define LDS_BIT_AMP1_EN 5
`define LDS_BIT_OFS_HI 3
`define LDS_BIT_OFS_LO 2
`define LDS_BIT_GAIN_HI 1
`define LDS_BIT_GAIN_LO 0
`define LDS_BIT_BEMF_EN 0
`define LDS_BIT_DIAG_EN 0
`define LDS_BIT_HP_UV 1
`define LDS_BIT_LP_UV 0

// Amplifier settling time
`define LDS_AMP_SETTLE_US 20
`define LDS_CLK_MHZ 50
`define LDS_AMP_SETTLE_CYC (`LDS_AMP_SETTLE_US * `LDS_CLK_MHZ)

`endif

// ===== rtl/lds_pkg.sv
package lds_pkg;

   typedef enum logic [2:0] {
      LDS_GDU_OFF = 3'b001,
      LDS_GDU_STANDBY = 3'b100,
      LDS_GDU_NORMAL = 3'b111
   } lds_gdu_mode_e;

   typedef enum logic [0:0] {
      LDS_PUMP_IDLE = 1'b0,
      LDS_PUMP_RUN = 1'b1
   } lds_pump_e;

   typedef logic [9:0] lds_cnt_t;

endpackage : lds_pkg

// ===== rtl/lds_ctrl.sv
`timescale 1ns/1ps
`include "lds_cfg.svh"
// Functional notes
// - Amp three on only in device Standby/Normal with its enable bit set.
// - Amp one on only in device Standby/Normal with its enable bit set.
// - Amp output counts as unsettled for 20 us after enabling.
// - Amp one and back-EMF enables both set disable both functions.
// - Offset bits 3:2 pick io_supply /16, /8, /4 or /2.
// - Gain bits 1:0 pick gain 8, 16, 32 or 64.
// - Amp three output is routed to the current limit monitor.
// - Back-EMF enabled presents three zero-cross results, one per phase.
// - Line diagnostics need valid supply, device Normal, driver unit Standby.
// - Diagnostics control bit 0 enables diagnostics, only in driver Standby.
// - Active diagnostics ignore all six PWM gate inputs.
// - Active diagnostics copy comparator outputs continuously into results.
// - Diagnostics control bits 6:1 switch source and sink per phase.
// - Results bits 5:0 high/low per phase, bits 7:6 read zero.
// - Every changing write to diagnostics control clears results; only active diagnostics then refill them.
// - High-side pump runs in driver Standby or Normal, else stopped.
// - Low-side pump in driver Standby/Normal: on below start threshold, off above stop threshold; else stopped.
// - Undervoltage on either pump output sets its status flag.
// - Driver mode field: 001 Off, 100 Standby, 111 Normal, others invalid.
// - Back-EMF enable bit 0 at 0x05; zero releases pins to amp one.
module lds_ctrl
   import lds_pkg::*;
#(
   parameter lds_cnt_t AMP_SETTLE_CYC = lds_cnt_t'(`LDS_AMP_SETTLE_CYC)
) (
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Register access from the serial interface
   input wire logic [6:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Operating state from the mode controllers
   input wire logic dev_standby,
   input wire logic dev_normal,
   input wire logic [2:0] gdu_state,
   // Analog comparator and gate control pins
   input wire logic vs_in_range,
   input wire logic vs_below_start,
   input wire logic vs_above_stop,
   input wire logic high_pump_uv_cmp,
   input wire logic low_pump_uv_cmp,
   input wire logic [2:0] zero_cross_cmp,
   input wire logic [2:0] diag_high_cmp,
   input wire logic [2:0] diag_low_cmp,
   input wire logic [2:0] high_side_pwm_in_n,
   input wire logic [2:0] low_side_pwm_in,
   // Sense amplifier controls
   output logic amp_three_on,
   output logic amp_one_on,
   output logic amp_three_settled,
   output logic amp_one_settled,
   output logic [1:0] amp_gain_sel,
   output logic [1:0] amp_offset_sel,
   output logic amp_three_to_limit,
   // Back-EMF feedback
   output logic back_emf_on,
   output logic fb_pins_to_amp_one,
   output logic [2:0] zero_cross_out,
   // Line diagnostics
   output logic line_diag_active,
   output logic [2:0] phase_source_on,
   output logic [2:0] phase_sink_on,
   // Gate commands
   output logic [2:0] gate_high_n,
   output logic [2:0] gate_low,
   // Charge pumps and mode request
   output logic high_side_pump_on,
   output logic low_side_pump_on,
   output logic [2:0] driver_unit_mode_sel,
   output logic driver_mode_invalid
);

   localparam int SYNC_W = 20;
   // High-side PWM pins are active low: reset them to idle so no gate turns on after reset
   localparam logic [SYNC_W-1:0] SYNC_RST = 20'h00700;

   // Two-stage synchronisers for all pins
   logic [SYNC_W-1:0] pin_raw;
   logic [SYNC_W-1:0] sync1_q;
   logic [SYNC_W-1:0] sync2_q;

   assign pin_raw = {zero_cross_cmp, diag_high_cmp, diag_low_cmp, high_side_pwm_in_n,
                     low_side_pwm_in, vs_in_range, vs_below_start, vs_above_stop,
                     high_pump_uv_cmp, low_pump_uv_cmp};

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         sync1_q <= SYNC_RST;
         sync2_q <= SYNC_RST;
      end else begin
         sync1_q <= pin_raw;
         sync2_q <= sync1_q;
      end
   end

   logic [2:0] zc_s;
   logic [2:0] dh_s;
   logic [2:0] dl_s;
   logic [2:0] hpwm_n_s;
   logic [2:0] lpwm_s;
   logic vs_ok_s;
   logic below_start_s;
   logic above_stop_s;
   logic hp_uv_s;
   logic lp_uv_s;

   assign {zc_s, dh_s, dl_s, hpwm_n_s, lpwm_s, vs_ok_s, below_start_s, above_stop_s,
           hp_uv_s, lp_uv_s} = sync2_q;

   // Register state
   logic [2:0] mode_q, mode_d;
   logic [7:0] drvctl_q, drvctl_d;
   logic [7:0] amp_q, amp_d;
   logic [7:0] diag_q, diag_d;
   logic [5:0] res_q, res_d;
   logic [1:0] irq_q, irq_d;
   lds_cnt_t settle_q [2];
   lds_cnt_t settle_d [2];
   lds_pump_e lpump_q, lpump_d;
   logic [7:0] rdata_d;

   // Output state
   logic amp3_d, amp1_d, bemf_d, diag_act_d, hpump_d;
   logic [1:0] settled_d;
   logic [2:0] zc_d, src_d, snk_d, gh_n_d, gl_d;

   logic dev_active;
   logic gdu_standby;
   logic gdu_running;
   logic amp_conflict;
   logic diag_ok;
   logic diag_chg;
   logic [1:0] amp_en;
   logic [7:0] diag_wr;
   logic [5:0] cmp_res;

   always_comb begin
      dev_active = dev_standby | dev_normal;
      gdu_standby = (gdu_state == LDS_GDU_STANDBY);
      gdu_running = gdu_standby | (gdu_state == LDS_GDU_NORMAL);

      // Register writes
      mode_d = mode_q;
      drvctl_d = drvctl_q;
      amp_d = amp_q;
      diag_d = diag_q;
      diag_wr = reg_wdata & `LDS_MASK_DIAG_CTRL;
      diag_chg = 1'b0;
      if (reg_wr) begin
         case (reg_addr)
            `LDS_ADDR_DRV_MODE: mode_d = reg_wdata[2:0];
            `LDS_ADDR_DRV_CTRL1: drvctl_d = reg_wdata;
            `LDS_ADDR_AMP_CTRL: amp_d = reg_wdata & `LDS_MASK_AMP_CTRL;
            `LDS_ADDR_DIAG_CTRL: begin
               diag_d = diag_wr;
               diag_chg = (diag_wr != diag_q);
            end
            default: ;
         endcase
      end

      // Amplifier and back-EMF enables
      amp_conflict = amp_q[`LDS_BIT_AMP1_EN] & drvctl_q[`LDS_BIT_BEMF_EN];
      amp3_d = dev_active & amp_q[`LDS_BIT_AMP3_EN];
      amp1_d = dev_active & amp_q[`LDS_BIT_AMP1_EN] & ~amp_conflict;
      bemf_d = drvctl_q[`LDS_BIT_BEMF_EN] & ~amp_conflict;
      zc_d = bemf_d ? zc_s : 3'h0;

      // Settling counters restart whenever an amplifier is switched off
      amp_en = {amp3_d, amp1_d};
      for (int i = 0; i < 2; i++) begin
         if (!amp_en[i]) begin
            settle_d[i] = '0;
         end else if (settle_q[i] != AMP_SETTLE_CYC) begin
            settle_d[i] = settle_q[i] + lds_cnt_t'(1);
         end else begin
            settle_d[i] = settle_q[i];
         end
         settled_d[i] = amp_en[i] && (settle_q[i] == AMP_SETTLE_CYC);
      end

      // Line diagnostics
      diag_ok = vs_ok_s & dev_normal & gdu_standby;
      diag_act_d = diag_ok & diag_q[`LDS_BIT_DIAG_EN];
      for (int p = 0; p < 3; p++) begin
         src_d[p] = diag_act_d & diag_q[2*p+2];
         snk_d[p] = diag_act_d & diag_q[2*p+1];
         cmp_res[2*p+1] = dh_s[p];
         cmp_res[2*p] = dl_s[p];
      end
      // A changing write discards results taken under the old setup
      if (diag_chg) begin
         res_d = 6'h00;
      end else if (diag_act_d) begin
         res_d = cmp_res;
      end else begin
         res_d = res_q;
      end

      // PWM inputs are blocked while diagnostics drive the lines
      gh_n_d = diag_act_d ? 3'h7 : hpwm_n_s;
      gl_d = diag_act_d ? 3'h0 : lpwm_s;

      // Charge pumps
      hpump_d = gdu_running;
      if (!gdu_running) begin
         lpump_d = LDS_PUMP_IDLE;
      end else if (below_start_s) begin
         lpump_d = LDS_PUMP_RUN;
      end else if (above_stop_s) begin
         lpump_d = LDS_PUMP_IDLE;
      end else begin
         lpump_d = lpump_q;
      end

      // Undervoltage flags: write one clears, a new event wins
      irq_d = irq_q;
      if (reg_wr && reg_addr == `LDS_ADDR_IRQ_STAT3) begin
         irq_d = irq_q & ~reg_wdata[1:0];
      end
      irq_d[`LDS_BIT_HP_UV] = irq_d[`LDS_BIT_HP_UV] | hp_uv_s;
      irq_d[`LDS_BIT_LP_UV] = irq_d[`LDS_BIT_LP_UV] | lp_uv_s;

      // Read data, one cycle after the address
      case (reg_addr)
         `LDS_ADDR_DRV_MODE: rdata_d = {5'h00, mode_q};
         `LDS_ADDR_DRV_CTRL1: rdata_d = drvctl_q;
         `LDS_ADDR_AMP_CTRL: rdata_d = amp_q;
         `LDS_ADDR_DIAG_CTRL: rdata_d = diag_q;
         `LDS_ADDR_DIAG_RES: rdata_d = {2'h0, res_q};
         `LDS_ADDR_IRQ_STAT3: rdata_d = {6'h00, irq_q};
         default: rdata_d = 8'h00;
      endcase
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         mode_q <= `LDS_RST_DRV_MODE;
         drvctl_q <= `LDS_RST_DRV_CTRL1;
         amp_q <= `LDS_RST_AMP_CTRL;
         diag_q <= `LDS_RST_DIAG_CTRL;
         res_q <= 6'h00;
         irq_q <= 2'h0;
         settle_q[0] <= '0;
         settle_q[1] <= '0;
         lpump_q <= LDS_PUMP_IDLE;
         reg_rdata <= 8'h00;
         amp_three_on <= 1'b0;
         amp_one_on <= 1'b0;
         amp_three_settled <= 1'b0;
         amp_one_settled <= 1'b0;
         amp_gain_sel <= 2'h0;
         amp_offset_sel <= 2'h0;
         amp_three_to_limit <= 1'b0;
         back_emf_on <= 1'b0;
         fb_pins_to_amp_one <= 1'b1;
         zero_cross_out <= 3'h0;
         line_diag_active <= 1'b0;
         phase_source_on <= 3'h0;
         phase_sink_on <= 3'h0;
         gate_high_n <= 3'h7;
         gate_low <= 3'h0;
         high_side_pump_on <= 1'b0;
         low_side_pump_on <= 1'b0;
         driver_unit_mode_sel <= `LDS_RST_DRV_MODE;
         driver_mode_invalid <= 1'b0;
      end else begin
         mode_q <= mode_d;
         drvctl_q <= drvctl_d;
         amp_q <= amp_d;
         diag_q <= diag_d;
         res_q <= res_d;
         irq_q <= irq_d;
         settle_q <= settle_d;
         lpump_q <= lpump_d;
         reg_rdata <= rdata_d;
         amp_three_on <= amp3_d;
         amp_one_on <= amp1_d;
         amp_three_settled <= settled_d[1];
         amp_one_settled <= settled_d[0];
         amp_gain_sel <= amp_q[`LDS_BIT_GAIN_HI:`LDS_BIT_GAIN_LO];
         amp_offset_sel <= amp_q[`LDS_BIT_OFS_HI:`LDS_BIT_OFS_LO];
         amp_three_to_limit <= amp3_d;
         back_emf_on <= bemf_d;
         fb_pins_to_amp_one <= ~bemf_d;
         zero_cross_out <= zc_d;
         line_diag_active <= diag_act_d;
         phase_source_on <= src_d;
         phase_sink_on <= snk_d;
         gate_high_n <= gh_n_d;
         gate_low <= gl_d;
         high_side_pump_on <= hpump_d;
         low_side_pump_on <= (lpump_d == LDS_PUMP_RUN);
         driver_unit_mode_sel <= mode_q;
         driver_mode_invalid <= !(mode_q == LDS_GDU_OFF || mode_q == LDS_GDU_STANDBY ||
                                  mode_q == LDS_GDU_NORMAL);
      end
   end

endmodule : lds_ctrl

// ===== sim/lds_line_model.sv
`timescale 1ns/1ps
module lds_line_model (
   // Current source enables
   input wire logic [2:0] phase_source_on,
   input wire logic [2:0] phase_sink_on,
   // Comparator levels
   output logic [2:0] diag_high_cmp,
   output logic [2:0] diag_low_cmp
);
   // Open lines: a sink pulls low and wins, settling is slowed by board capacitance
   assign #200 diag_high_cmp = phase_source_on & ~phase_sink_on;
   assign #200 diag_low_cmp = phase_sink_on;
endmodule : lds_line_model

// ===== sim/lds_ctrl_monitor.sv
`timescale 1ns/1ps
module lds_ctrl_monitor (
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Watched ports
   input wire logic [6:0] reg_addr,
   input wire logic [7:0] reg_rdata,
   input wire logic dev_standby,
   input wire logic dev_normal,
   input wire logic [2:0] gdu_state,
   input wire logic amp_three_on,
   input wire logic amp_one_on,
   input wire logic amp_three_settled,
   input wire logic amp_three_to_limit,
   input wire logic back_emf_on,
   input wire logic fb_pins_to_amp_one,
   input wire logic line_diag_active,
   input wire logic [2:0] phase_source_on,
   input wire logic [2:0] phase_sink_on,
   input wire logic [2:0] gate_high_n,
   input wire logic [2:0] gate_low,
   input wire logic high_side_pump_on
);
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   sequence amp_rise;
      $rose(amp_three_on);
   endsequence
   sequence held_unsettled;
      !amp_three_settled [*8];
   endsequence
   a_limit_route: assert property (amp_three_to_limit == amp_three_on)
      else $error("limit route differs");
   a_amp_three_mode: assert property (amp_three_on |-> $past(dev_standby || dev_normal))
      else $error("amp three on outside mode");
   a_amp_one_excl: assert property (amp_one_on |-> !back_emf_on && $past(dev_standby || dev_normal))
      else $error("amp one on wrongly");
   a_settle_wait: assert property (amp_rise |-> held_unsettled)
      else $error("settled too early");
   a_fb_release: assert property (fb_pins_to_amp_one != back_emf_on)
      else $error("feedback pins wrong owner");
   a_pump_high: assert property (high_side_pump_on == ($past(gdu_state) inside {3'h4, 3'h7}))
      else $error("high pump state wrong");
   a_diag_cond: assert property (line_diag_active |-> $past(dev_normal) && $past(gdu_state) == 3'h4)
      else $error("diagnostics active wrongly");
   a_pwm_ignored: assert property (line_diag_active |-> gate_high_n == 3'h7 && gate_low == 3'h0)
      else $error("gates driven in diagnostics");
   a_sources_off: assert property (!line_diag_active |-> (phase_source_on | phase_sink_on) == 3'h0)
      else $error("source on while inactive");
   a_res_top_zero: assert property (reg_addr == 7'h12 |=> reg_rdata[7:6] == 2'h0)
      else $error("result top bits set");
endmodule : lds_ctrl_monitor
bind lds_ctrl lds_ctrl_monitor u_mon (.*);

// ===== sim/lds_ctrl_test.sv
`timescale 1ns/1ps
module lds_ctrl_test;
   import lds_pkg::*;
   logic clock = 0, nrst = 0, reg_wr = 0, dev_standby = 0, dev_normal = 0;
   logic vs_in_range = 0, vs_below_start = 0, vs_above_stop = 0, uv_h = 0, uv_l = 0;
   logic [6:0] reg_addr = 0;
   logic [7:0] reg_wdata = 0, rd, ctl;
   logic [15:0] e;
   logic [2:0] gdu_state = 3'h1, zc = 0, pwm_n = 3'h7, pwm = 0, hc, lc, src, snk, ghn, gl, zco, ms;
   logic a3, a1, a3s, a1s, bemf, act, hpo, lpo, inv;
   logic [1:0] gs, os;
   logic [31:0] rs = 32'hEDE1;
   int err_total = 0, num_checks = 0, cyc = 0;
   lds_ctrl #(.AMP_SETTLE_CYC(lds_cnt_t'(10))) u_dut (.clock(clock), .nrst(nrst),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(rd),
      .dev_standby(dev_standby), .dev_normal(dev_normal), .gdu_state(gdu_state),
      .vs_in_range(vs_in_range), .vs_below_start(vs_below_start), .vs_above_stop(vs_above_stop),
      .high_pump_uv_cmp(uv_h), .low_pump_uv_cmp(uv_l), .zero_cross_cmp(zc),
      .diag_high_cmp(hc), .diag_low_cmp(lc), .high_side_pwm_in_n(pwm_n), .low_side_pwm_in(pwm),
      .amp_three_on(a3), .amp_one_on(a1), .amp_three_settled(a3s), .amp_one_settled(a1s),
      .amp_gain_sel(gs), .amp_offset_sel(os), .amp_three_to_limit(), .back_emf_on(bemf),
      .fb_pins_to_amp_one(), .zero_cross_out(zco), .line_diag_active(act),
      .phase_source_on(src), .phase_sink_on(snk), .gate_high_n(ghn), .gate_low(gl),
      .high_side_pump_on(hpo), .low_side_pump_on(lpo), .driver_unit_mode_sel(ms),
      .driver_mode_invalid(inv));
   lds_line_model u_line (.phase_source_on(src), .phase_sink_on(snk),
      .diag_high_cmp(hc), .diag_low_cmp(lc));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   // Upper byte: sources then sinks; lower byte: expected results
   function automatic logic [15:0] diag_exp(input logic [7:0] c);
      diag_exp = 16'h0000;
      for (int p = 0; p < 3; p++) begin
         diag_exp[p+11] = c[2*p+2];
         diag_exp[p+8] = c[2*p+1];
         diag_exp[2*p+1] = c[2*p+2] & ~c[2*p+1];
         diag_exp[2*p] = c[2*p+1];
      end
   endfunction : diag_exp
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : tick
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wr <= 1'b1;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
      tick(6);
   endtask : wr
   task automatic rc(input logic [6:0] a, input logic [7:0] x);
      @(posedge clock);
      reg_addr <= a;
      tick(2);
      chk(rd, x);
   endtask : rc
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : report_and_stop
   initial begin
      forever #10 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         report_and_stop();
      end
   end
   initial begin
      tick(16);
      @(posedge clock);
      nrst <= 1'b1;
      tick(1);
      chk({5'h0, ghn}, 8'h07);
      rc(7'h03, 8'h01);
      rc(7'h05, 8'h1E);
      rc(7'h0C, 8'hA0);
      rc(7'h0E, 8'h00);
      rc(7'h40, 8'h00);
      wr(7'h12, 8'hFF);
      rc(7'h12, 8'h00);
      wr(7'h0C, 8'hFF);
      rc(7'h0C, 8'hAF);
      chk({7'h0, a3}, 8'h00);
      @(posedge clock);
      dev_standby <= 1'b1;
      tick(3);
      chk({4'h0, a3s, a1s, a3, a1}, 8'h03);
      tick(7);
      chk({6'h0, a3s, a1s}, 8'h00);
      tick(1);
      chk({6'h0, a3s, a1s}, 8'h03);
      wr(7'h05, 8'h1F);
      chk({6'h0, a1, bemf}, 8'h00);
      wr(7'h0C, 8'h80);
      @(posedge clock);
      zc <= 3'h5;
      tick(5);
      chk({4'h0, bemf, zco}, 8'h0D);
      for (int i = 0; i < 16; i++) begin
         wr(7'h0C, 8'(i));
         chk({4'h0, os, gs}, 8'(i));
      end
      $display("amplifier tests done");
      @(posedge clock);
      dev_standby <= 1'b0;
      dev_normal <= 1'b1;
      gdu_state <= 3'h4;
      vs_in_range <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         rs = xs(rs);
         ctl = (i == 0) ? 8'h7F : {1'b0, rs[6:1], 1'b1};
         e = diag_exp(ctl);
         @(posedge clock);
         pwm <= rs[10:8];
         pwm_n <= rs[13:11];
         wr(7'h0E, ctl);
         tick(10);
         chk({1'b0, act, src, snk}, {1'b0, 1'b1, e[13:8]});
         chk({2'h0, ghn, gl}, 8'h38);
         rc(7'h12, e[7:0]);
      end
      @(posedge clock);
      gdu_state <= 3'h7;
      tick(6);
      chk({1'b0, act, src, snk}, 8'h00);
      chk({2'h0, ghn, gl}, {2'h0, pwm_n, pwm});
      wr(7'h0E, 8'h7E);
      @(posedge clock);
      gdu_state <= 3'h4;
      tick(6);
      chk({1'b0, act, src, snk}, 8'h00);
      $display("diagnostics tests done");
      @(posedge clock);
      vs_below_start <= 1'b1;
      tick(6);
      chk({6'h0, hpo, lpo}, 8'h03);
      @(posedge clock);
      vs_below_start <= 1'b0;
      vs_above_stop <= 1'b1;
      tick(6);
      chk({6'h0, hpo, lpo}, 8'h02);
      @(posedge clock);
      gdu_state <= 3'h1;
      tick(6);
      chk({6'h0, hpo, lpo}, 8'h00);
      for (int b = 0; b < 2; b++) begin
         @(posedge clock);
         {uv_h, uv_l} <= 2'(1 << b);
         tick(5);
         @(posedge clock);
         {uv_h, uv_l} <= 2'h0;
         rc(7'h15, 8'(1 << b));
         wr(7'h15, 8'h03);
         rc(7'h15, 8'h00);
      end
      $display("pump tests done");
      wr(7'h03, 8'h05);
      chk({4'h0, inv, ms}, 8'h0D);
      wr(7'h03, 8'h04);
      chk({4'h0, inv, ms}, 8'h04);
      $display("mode tests done");
      report_and_stop();
   end
endmodule : lds_ctrl_test
